// >>> hdl/cab_core.sv
// Execution core for add, AND, bit clear and flag branches, with a Wishbone slave.
// Operation
// - Add literal to accumulator, result to accumulator, update all five flags.
// - Add accumulator to file register, result to destination, update all five flags.
// - Add accumulator, carry and file register, update all five flags.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Bank bit 0 uses the access bank, 1 uses the bank select register.
// - AND literal with accumulator into accumulator, update only N and Z.
// - AND accumulator with file register to destination, update only N and Z.
// - Clear one indexed bit of a file register, other bits and flags unchanged.
// - Taken branch target is incremented PC plus twice signed offset, flags untouched.
// - Branch takes one cycle if not taken, two if taken, second is no-op.
// - Branch when carry set, else fall through.
// - Branch when negative set, else fall through.
// - Branch when carry clear, else fall through.
// - Branch when negative clear, else fall through.
// - Branch when overflow clear, else fall through.
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module cab_core
  import cab_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Wishbone classic slave.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O
);

  cab_alu_if alu_bus ();

  cab_alu u_alu (
    .alu(alu_bus)
  );

  cab_state_t st, next_st;
  logic [15:0] opcode, next_opcode;
  logic [7:0] accum, next_accum;
  logic [4:0] status, next_status;
  logic [PC_W-1:0] pc, next_pc;
  logic [3:0] bank, next_bank;
  logic [DADDR_W-1:0] dptr, next_dptr;
  logic [7:0] operand, next_operand;
  logic [7:0] result, next_result;
  logic [4:0] rflags, next_rflags;
  logic taken, next_taken;
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic [7:0] dmem [DMEM_DEPTH];
  logic mem_we;
  logic [DADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic req;
  logic start;
  logic busy;
  logic is_add_lit, is_and_lit, is_add_file, is_addc_file, is_and_file, is_clr_bit;
  logic is_file, is_branch, br_hit, dest_file;
  logic [DADDR_W-1:0] eff_addr;
  logic [31:0] wr_word;

  // Merge a write into an old word, taking only the lanes that sel enables.
  function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : sel_merge

  // Data memory address from bank bit, file address and bank select.
  function automatic logic [DADDR_W-1:0] file_addr(input logic a, input logic [7:0] f,
                                                   input logic [3:0] bsel);
    logic [DADDR_W-1:0] r;
    r = {bsel, f};
    if (!a) begin
      r = {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    end
    return r;
  endfunction : file_addr

  // Bus request and decode of the latched opcode.
  assign req = WB_CYC_I && WB_STB_I && !ack;
  assign busy = (st != ST_IDLE);
  assign start = req && WB_WE_I && !busy && (WB_ADR_I[7:2] == ADDR_INSTR[7:2]);
  assign is_add_lit = (opcode[15:8] == OPC_ADD_LIT);
  assign is_and_lit = (opcode[15:8] == OPC_AND_LIT);
  assign is_add_file = (opcode[15:10] == OPH_ADD_FILE);
  assign is_addc_file = (opcode[15:10] == OPH_ADDC_FILE);
  assign is_and_file = (opcode[15:10] == OPH_AND_FILE);
  assign is_clr_bit = (opcode[15:12] == OPN_CLR_BIT);
  assign is_file = is_add_file || is_addc_file || is_and_file || is_clr_bit;
  assign dest_file = is_clr_bit || opcode[9];
  assign eff_addr = file_addr(opcode[8], opcode[7:0], bank);

  // Branch condition per opcode; anything else is not a branch.
  always_comb begin
    is_branch = 1'b1;
    br_hit = 1'b0;
    case (opcode[15:8])
      OPC_BR_CARRY_SET: br_hit = status[FLAG_C];
      OPC_BR_CARRY_CLR: br_hit = !status[FLAG_C];
      OPC_BR_OVF_CLR: br_hit = !status[FLAG_OVERFLOW];
      OPC_BR_NEG_SET: br_hit = status[FLAG_N];
      OPC_BR_NEG_CLR: br_hit = !status[FLAG_N];
      default: is_branch = 1'b0;
    endcase
  end

  // Arithmetic unit operands, only meaningful in the compute phase.
  always_comb begin
    alu_bus.op = (is_and_lit || is_and_file || is_clr_bit) ? ALU_AND : ALU_ADD;
    // mask keeps every bit but the indexed one
    alu_bus.opa = is_clr_bit ? ~(8'h01 << opcode[11:9]) : accum;
    alu_bus.opb = operand;
    alu_bus.cin = is_addc_file && status[FLAG_C];
  end

  // Next state of the sequencer, the programmer registers and the bus answer.
  always_comb begin
    next_st = st;
    next_opcode = opcode;
    next_accum = accum;
    next_status = status;
    next_pc = pc;
    next_bank = bank;
    next_dptr = dptr;
    next_operand = operand;
    next_result = result;
    next_rflags = rflags;
    next_taken = taken;
    next_ack = 1'b0;
    next_dat = dat;
    mem_we = 1'b0;
    mem_wa = eff_addr;
    mem_wd = result;
    wr_word = 32'h00000000;
    // Reads are served at any time; writes only while idle, so software
    // cannot race the sequencer for the same register.
    if (req) begin
      next_ack = 1'b1;
      next_dat = 32'h00000000;
      case (WB_ADR_I[7:2])
        ADDR_INSTR[7:2]: begin
          next_dat = {16'h0000, opcode};
          wr_word = sel_merge({16'h0000, opcode}, WB_DAT_I, WB_SEL_I);
          if (start) begin
            next_opcode = wr_word[15:0];
            next_pc = pc + PC_STEP;
            next_st = ST_Q1;
          end
        end
        ADDR_ACCUM[7:2]: begin
          next_dat = {24'h000000, accum};
          wr_word = sel_merge({24'h000000, accum}, WB_DAT_I, WB_SEL_I);
          if (WB_WE_I && !busy) next_accum = wr_word[7:0];
        end
        ADDR_STATUS[7:2]: begin
          next_dat = {23'h000000, busy, 3'h0, status};
          wr_word = sel_merge({27'h0000000, status}, WB_DAT_I, WB_SEL_I);
          if (WB_WE_I && !busy) next_status = wr_word[4:0];
        end
        ADDR_PC[7:2]: begin
          next_dat = {11'h000, pc};
          wr_word = sel_merge({11'h000, pc}, WB_DAT_I, WB_SEL_I);
          if (WB_WE_I && !busy) next_pc = wr_word[PC_W-1:0];
        end
        ADDR_BANK[7:2]: begin
          next_dat = {28'h0000000, bank};
          wr_word = sel_merge({28'h0000000, bank}, WB_DAT_I, WB_SEL_I);
          if (WB_WE_I && !busy) next_bank = wr_word[3:0];
        end
        ADDR_DPTR[7:2]: begin
          next_dat = {20'h00000, dptr};
          wr_word = sel_merge({20'h00000, dptr}, WB_DAT_I, WB_SEL_I);
          if (WB_WE_I && !busy) next_dptr = wr_word[DADDR_W-1:0];
        end
        ADDR_DATA[7:2]: begin
          next_dat = {24'h000000, dmem[dptr]};
          if (WB_WE_I && !busy && WB_SEL_I[0]) begin
            mem_we = 1'b1;
            mem_wa = dptr;
            mem_wd = WB_DAT_I[7:0];
          end
        end
        default: next_dat = 32'h00000000;
      endcase
    end
    unique case (st)
      ST_IDLE: next_st = next_st;
      ST_Q1: next_st = ST_Q2;
      ST_Q2: begin
        // File ops read data memory, all others read the literal field.
        next_operand = is_file ? dmem[eff_addr] : opcode[7:0];
        next_st = ST_Q3;
      end
      ST_Q3: begin
        next_result = alu_bus.res;
        next_rflags = {alu_bus.n, alu_bus.overflow_flag, alu_bus.z, alu_bus.digit_carry_flag,
                       alu_bus.c};
        next_taken = is_branch && br_hit;
        next_st = ST_Q4;
      end
      ST_Q4: begin
        next_st = ST_IDLE;
        if (is_add_lit) next_accum = result;
        if (is_and_lit) next_accum = result;
        // file add, add with carry and AND results go to the selected destination
        if (is_add_file || is_addc_file || is_and_file) begin
          if (dest_file) begin
            mem_we = 1'b1;
          end else begin
            next_accum = result;
          end
        end
        // bit clear writes back, flags untouched
        if (is_clr_bit) mem_we = 1'b1;
        // all five flags from the add
        if (is_add_lit || is_add_file || is_addc_file) next_status = rflags;
        // logic ops keep carry, digit carry and overflow
        if (is_and_lit || is_and_file) begin
          next_status[FLAG_N] = rflags[FLAG_N];
          next_status[FLAG_Z] = rflags[FLAG_Z];
        end
        // relative target from the incremented PC
        if (taken) begin
          next_pc = pc + PC_W'({{12{operand[7]}}, operand, 1'b0});
          next_st = ST_N1;
        end
        // untaken branch leaves the PC alone
      end
      // second cycle of a taken branch does nothing
      ST_N1: next_st = ST_N2;
      ST_N2: next_st = ST_N3;
      ST_N3: next_st = ST_N4;
      ST_N4: next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  // Register the state; the memory has no reset, as in any data RAM.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= ST_IDLE;
      opcode <= 16'h0000;
      accum <= RST_ACCUM;
      status <= RST_STATUS;
      pc <= RST_PC;
      bank <= RST_BANK;
      dptr <= RST_DPTR;
      operand <= 8'h00;
      result <= 8'h00;
      rflags <= 5'h00;
      taken <= 1'b0;
      ack <= 1'b0;
      dat <= 32'h00000000;
    end else begin
      st <= next_st;
      opcode <= next_opcode;
      accum <= next_accum;
      status <= next_status;
      pc <= next_pc;
      bank <= next_bank;
      dptr <= next_dptr;
      operand <= next_operand;
      result <= next_result;
      rflags <= next_rflags;
      taken <= next_taken;
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  // Data memory write port, shared by bus and sequencer which never overlap.
  always_ff @(posedge REF_CLK) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = dat;

  // Checks next to the logic they guard.
  add_literal_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    start && (WB_DAT_I[15:8] == OPC_ADD_LIT) && (WB_SEL_I == 4'hF)
    |-> ##5 accum == 8'($past(accum, 5) + opcode[7:0]))
    else $error("Add literal result wrong.");

  and_literal_flags_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q4) && is_and_lit |=> status[FLAG_C] == $past(status[FLAG_C])
    && status[FLAG_OVERFLOW] == $past(status[FLAG_OVERFLOW])
    && status[FLAG_DIGIT_CARRY] == $past(status[FLAG_DIGIT_CARRY]))
    else $error("AND literal changed a protected flag.");

  bit_clear_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q4) && is_clr_bit |=> dmem[$past(eff_addr)][$past(opcode[11:9])] == 1'b0
    && status == $past(status))
    else $error("Bit clear failed or touched flags.");

  branch_target_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q4) && taken
    |=> pc == PC_W'($past(pc) + {{12{$past(operand[7])}}, $past(operand), 1'b0})
    && status == $past(status))
    else $error("Branch target or flags wrong.");

  taken_two_cycles_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q4) && taken |=> (st == ST_N1) ##1 (st == ST_N2) ##1 (st == ST_N3)
    ##1 (st == ST_N4) ##1 (st == ST_IDLE))
    else $error("Taken branch cycle count wrong.");

  untaken_pc_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q4) && is_branch && !taken |=> (pc == $past(pc)) && (st == ST_IDLE))
    else $error("Untaken branch wrote the PC.");

  one_cycle_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    start |=> (st == ST_Q1) ##1 (st == ST_Q2) ##1 (st == ST_Q3) ##1 (st == ST_Q4)
    ##1 (st == ST_IDLE || st == ST_N1))
    else $error("Instruction phase sequence wrong.");

  dest_accum_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q4) && (is_add_file || is_and_file) && !opcode[9] |=> accum == $past(result))
    else $error("Destination accumulator not written.");

  access_bank_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (st == ST_Q2) && is_file && !opcode[8]
    |-> eff_addr[11:8] == (opcode[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK))
    else $error("Access bank address wrong.");

endmodule : cab_core

// >>> hdl/cab_pkg.sv
// Shared constants and types for the add, logic and branch execution block.
package cab_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_ACCUM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;
  localparam logic [7:0] ADDR_BANK = 8'h10;
  localparam logic [7:0] ADDR_DPTR = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;

  // Status field positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_DIGIT_CARRY = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_N = 4;
  localparam int STATUS_BUSY = 8;

  // Widths.
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int DMEM_DEPTH = 4096;

  // Reset values.
  localparam logic [7:0] RST_ACCUM = 8'h00;
  localparam logic [4:0] RST_STATUS = 5'h00;
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [DADDR_W-1:0] RST_DPTR = 12'h000;

  // Opcode encodings.
  localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
  localparam logic [7:0] OPC_AND_LIT = 8'h0B;
  localparam logic [5:0] OPH_ADD_FILE = 6'h09;
  localparam logic [5:0] OPH_ADDC_FILE = 6'h08;
  localparam logic [5:0] OPH_AND_FILE = 6'h05;
  localparam logic [3:0] OPN_CLR_BIT = 4'h9;
  localparam logic [7:0] OPC_BR_CARRY_SET = 8'hE2;
  localparam logic [7:0] OPC_BR_CARRY_CLR = 8'hE3;
  localparam logic [7:0] OPC_BR_OVF_CLR = 8'hE5;
  localparam logic [7:0] OPC_BR_NEG_SET = 8'hE6;
  localparam logic [7:0] OPC_BR_NEG_CLR = 8'hE7;

  // Access bank split and program counter step.
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Arithmetic unit operations.
  typedef enum logic {
    ALU_ADD = 1'h0,
    ALU_AND = 1'h1
  } cab_alu_op_t;

  // Execution phases, one-hot; N1..N4 is the refetch cycle of a taken branch.
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_Q1 = 9'h002,
    ST_Q2 = 9'h004,
    ST_Q3 = 9'h008,
    ST_Q4 = 9'h010,
    ST_N1 = 9'h020,
    ST_N2 = 9'h040,
    ST_N3 = 9'h080,
    ST_N4 = 9'h100
  } cab_state_t;

endpackage : cab_pkg

// >>> hdl/cab_alu_if.sv
// Interface between the execution core and its arithmetic unit.
`timescale 1ns/1ps
interface cab_alu_if;
  import cab_pkg::*;
  cab_alu_op_t op;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [7:0] res;
  logic c;
  logic digit_carry_flag;
  logic overflow_flag;
  logic n;
  logic z;

  modport core (output op, opa, opb, cin, input res, c, digit_carry_flag, overflow_flag, n, z);
  modport alu (input op, opa, opb, cin, output res, c, digit_carry_flag, overflow_flag, n, z);
endinterface : cab_alu_if

// >>> hdl/cab_alu.sv
// Eight-bit adder and AND unit with status flag generation.
`timescale 1ns/1ps
module cab_alu
  import cab_pkg::*;
(
  // Operands in, result and flags out.
  cab_alu_if.alu alu
);

  logic [8:0] sum9;
  logic [4:0] nib5;

  // Result and flags; the core decides which flags it keeps.
  always_comb begin
    sum9 = {1'b0, alu.opa} + {1'b0, alu.opb} + {8'h00, alu.cin};
    nib5 = {1'b0, alu.opa[3:0]} + {1'b0, alu.opb[3:0]} + {4'h0, alu.cin};
    alu.res = 8'h00;
    alu.c = 1'b0;
    alu.digit_carry_flag = 1'b0;
    alu.overflow_flag = 1'b0;
    case (alu.op)
      ALU_ADD: begin
        alu.res = sum9[7:0];
        alu.c = sum9[8];
        alu.digit_carry_flag = nib5[4];
        // Signed overflow: equal operand signs but a different result sign.
        alu.overflow_flag = (alu.opa[7] == alu.opb[7]) && (sum9[7] != alu.opa[7]);
      end
      ALU_AND: begin
        alu.res = alu.opa & alu.opb;
      end
    endcase
    alu.n = alu.res[7];
    alu.z = (alu.res == 8'h00);
  end

endmodule : cab_alu

// >>> test/cpu_add_and_branch_ops_tb.sv
// Self-checking bench for the add, logic, bit clear and branch execution block.
`timescale 1ns/1ps
module cpu_add_and_branch_ops_tb
  import cab_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 32'h00000000;
  logic wb_ack;
  logic [31:0] wb_dat_r;
  logic [31:0] rd;
  int failures = 0;
  int n_compared = 0;
  // Branch table: opcode, flag position and the flag level that makes it jump.
  logic [7:0] br_opc [5] = '{OPC_BR_CARRY_SET, OPC_BR_NEG_SET, OPC_BR_CARRY_CLR,
                             OPC_BR_NEG_CLR, OPC_BR_OVF_CLR};
  int br_bit [5] = '{FLAG_C, FLAG_N, FLAG_C, FLAG_N, FLAG_OVERFLOW};
  logic br_when [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [4:0] fl;
  // Byte lanes that the next bus cycle enables.
  logic [3:0] lanes = 4'hF;

  cab_core u_dut (
    .REF_CLK(ref_clk),
    .RSTN(rstn),
    .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr),
    .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_dat_w),
    .WB_ACK_O(wb_ack),
    .WB_DAT_O(wb_dat_r)
  );

  // Free-running 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("Compared %0d values, %0d mismatches.", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_flag

  // One classic cycle; the request stands until ack is sampled high, so no slave
  // latency is assumed and a silent slave is cut off by a bounded count.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= lanes;
    wb_adr <= adr;
    wb_dat_w <= dat;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb_xfer(1'b0, adr, 32'h00000000, rd);
    chk_word(rd, exp, what);
  endtask : rdchk

  // Polls the busy bit; twenty reads is far beyond the longest instruction.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb_xfer(1'b0, ADDR_STATUS, 32'h00000000, rd);
      n++;
    end while (rd[STATUS_BUSY] !== 1'b0 && n < 20);
    chk_flag(rd[STATUS_BUSY], 1'b0, "busy cleared");
  endtask : wait_idle

  // Loads state, runs one opcode, checks accumulator, flags and the file byte.
  task automatic run(input logic [7:0] acc, input logic [4:0] st, input logic [3:0] bank,
                     input logic [11:0] dptr, input logic [7:0] mem, input logic [15:0] op,
                     input logic [7:0] acc_e, input logic [4:0] st_e, input logic [7:0] mem_e);
    wr(ADDR_ACCUM, {24'h000000, acc});
    wr(ADDR_STATUS, {27'h0000000, st});
    wr(ADDR_BANK, {28'h0000000, bank});
    wr(ADDR_DPTR, {20'h00000, dptr});
    wr(ADDR_DATA, {24'h000000, mem});
    wr(ADDR_INSTR, {16'h0000, op});
    wait_idle();
    rdchk(ADDR_INSTR, {16'h0000, op}, "last opcode");
    rdchk(ADDR_ACCUM, {24'h000000, acc_e}, "accumulator");
    rdchk(ADDR_STATUS, {27'h0000000, st_e}, "flags");
    rdchk(ADDR_DATA, {24'h000000, mem_e}, "file byte");
  endtask : run

  // Runs one branch from a known counter; the second status read falls in the
  // refetch cycle, so it tells a one-cycle branch from a two-cycle one.
  task automatic br(input logic [7:0] opc, input logic [7:0] n, input logic [4:0] flags,
                    input logic taken);
    logic [20:0] exp_pc;
    wr(ADDR_PC, 32'h00000100);
    wr(ADDR_STATUS, {27'h0000000, flags});
    wr(ADDR_INSTR, {16'h0000, opc, n});
    wb_xfer(1'b0, ADDR_STATUS, 32'h00000000, rd);
    chk_flag(rd[STATUS_BUSY], 1'b1, "busy in first cycle");
    wb_xfer(1'b0, ADDR_STATUS, 32'h00000000, rd);
    chk_flag(rd[STATUS_BUSY], taken, "busy in refetch cycle");
    wait_idle();
    exp_pc = taken ? 21'h000102 + {{12{n[7]}}, n, 1'b0} : 21'h000102;
    rdchk(ADDR_PC, {11'h000, exp_pc}, "counter after branch");
    rdchk(ADDR_STATUS, {27'h0000000, flags}, "flags after branch");
  endtask : br

  // Main sequence.
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rdchk(ADDR_ACCUM, 32'h00000000, "accumulator reset");
    rdchk(ADDR_STATUS, 32'h00000000, "status reset");
    rdchk(ADDR_PC, 32'h00000000, "counter reset");
    rdchk(ADDR_BANK, 32'h00000000, "bank reset");
    rdchk(ADDR_DPTR, 32'h00000000, "pointer reset");
    rdchk(ADDR_INSTR, 32'h00000000, "opcode reset");
    wr(8'h1C, 32'hFFFFFFFF);
    rdchk(8'h1C, 32'h00000000, "unmapped read");
    // A write with no lane enabled must leave the register as it was.
    lanes = 4'h0;
    wr(ADDR_ACCUM, 32'h000000AA);
    lanes = 4'hF;
    rdchk(ADDR_ACCUM, 32'h00000000, "write with no lanes");
    // A write while the sequencer runs is acknowledged but has no effect.
    wr(ADDR_INSTR, 32'h00000F15);
    wr(ADDR_ACCUM, 32'h000000FF);
    wait_idle();
    rdchk(ADDR_ACCUM, 32'h00000015, "write refused while busy");
    rdchk(ADDR_PC, 32'h00000002, "counter steps one word");
    // Literal add: plain, signed overflow, and carry with zero.
    run(8'h10, 5'h00, 4'h0, 12'h000, 8'h5A, 16'h0F15, 8'h25, 5'h00, 8'h5A);
    run(8'h7F, 5'h01, 4'h0, 12'h000, 8'h5A, 16'h0F01, 8'h80, 5'h1A, 8'h5A);
    run(8'hFF, 5'h00, 4'h0, 12'h000, 8'h5A, 16'h0F01, 8'h00, 5'h07, 8'h5A);
    // File add to either destination, banked.
    run(8'h17, 5'h00, 4'h2, 12'h245, 8'hC2, 16'h2745, 8'h17, 5'h10, 8'hD9);
    run(8'h17, 5'h00, 4'h2, 12'h245, 8'hC2, 16'h2545, 8'hD9, 5'h10, 8'hC2);
    // Add with carry through the high half of the access bank, bank register ignored.
    run(8'h4D, 5'h01, 4'h2, 12'hF85, 8'h02, 16'h2085, 8'h50, 5'h02, 8'h02);
    run(8'h4D, 5'h00, 4'h2, 12'hF85, 8'h02, 16'h2285, 8'h4D, 5'h00, 8'h4F);
    // AND forms keep carry, digit carry and overflow.
    run(8'hA3, 5'h0B, 4'h0, 12'h000, 8'h5A, 16'h0B5F, 8'h03, 5'h0B, 8'h5A);
    run(8'hA3, 5'h07, 4'h0, 12'h000, 8'h5A, 16'h0B80, 8'h80, 5'h13, 8'h5A);
    run(8'h3D, 5'h01, 4'h3, 12'h010, 8'hC2, 16'h1610, 8'h3D, 5'h05, 8'h00);
    // Bit clear at both ends of the bit index.
    run(8'h11, 5'h1F, 4'h2, 12'h245, 8'hC7, 16'h9F45, 8'h11, 5'h1F, 8'h47);
    run(8'h11, 5'h00, 4'h2, 12'hF90, 8'hFF, 16'h9090, 8'h11, 5'h00, 8'hFE);
    // Every branch, taken at an offset limit and not taken with all five flags flipped.
    for (int i = 0; i < 5; i++) begin
      fl = br_when[i] ? (5'h01 << br_bit[i]) : (5'h1F ^ (5'h01 << br_bit[i]));
      br(br_opc[i], (i % 2 == 0) ? 8'h80 : 8'h7F, fl, 1'b1);
      br(br_opc[i], 8'h7F, fl ^ 5'h1F, 1'b0);
    end
    summarize();
  end

  // Watchdog: the sequence needs well under a thousand cycles, so 20000 means a hang.
  initial begin
    #(20000 * 5);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : cpu_add_and_branch_ops_tb
